// ===== pfc_pkg.sv
package pfc_pkg;
  localparam logic [7:0] CMD_READ_POS   = 8'h00_F0;
  localparam logic [7:0] CMD_WRITE_POS  = 8'h00_0F;
  localparam logic [7:0] CMD_READ_CTRL  = 8'h00_AA;
  localparam logic [7:0] CMD_WRITE_CTRL = 8'h00_55;
  localparam logic [7:0] CMD_INC        = 8'h00_C3;
  localparam logic [7:0] CMD_DEC        = 8'h00_99;
  localparam logic [7:0] RELEASE_CODE   = 8'h00_96;
  localparam logic [7:0] FEATURE_VALUE  = 8'h00_F3;
  localparam logic [7:0] CTRL_PUMP_OFF  = 8'h00_0C;
  localparam logic [7:0] CTRL_PUMP_ON   = 8'h00_4C;
  localparam logic [7:0] CTRL_RESET     = 8'h00_0C;
  localparam logic [7:0] WIPER_RESET    = 8'h00_00;
  localparam logic [7:0] WIPER_MAX      = 8'h00_FF;
  localparam logic [7:0] WIPER_MIN      = 8'h00_00;
  localparam logic [7:0] ECHO_REJECT    = 8'h00_FF;
  localparam logic [7:0] CRC_POLY_REV   = 8'h00_8C;
  localparam logic [7:0] CRC_INIT       = 8'h00_00;
  localparam logic [1:0] WIPER_ONLY     = 2'h0;
  localparam int         CTRL_PUMP_BIT  = 6;
  localparam int         CTRL_SEL_LSB   = 0;
  localparam int         BYTE_LAST      = 7;
  localparam int         PAIR_LAST      = 15;
  localparam int         ID_BITS        = 56;
  localparam logic [2:0] BIT_LAST       = 3'h7;
  localparam logic [3:0] TX_ONE_BYTE    = 4'h7;
  localparam logic [3:0] TX_TWO_BYTES   = 4'hF;
  localparam logic [5:0] ID_LAST        = 6'h37;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_CMD    = 3'b001,
    ST_RXDATA = 3'b010,
    ST_ECHO   = 3'b011,
    ST_RXREL  = 3'b100,
    ST_SEND   = 3'b101,
    ST_TAIL   = 3'b110
  } pfc_state_t;
endpackage

// ===== pfc_crc8.sv
`timescale 1ns/1ps
module pfc_crc8 (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       clear,
  input  wire logic       shift,
  input  wire logic       din,
  output logic [7:0]      crc
);
  logic fb;
  assign fb = din ^ crc[0];

  // Serial generator for x^8 + x^5 + x^4 + 1, LSB first
  always_ff @(posedge sys_clk) begin
    if (rst || clear) begin
      crc <= pfc_pkg::CRC_INIT;
    end else if (shift) begin
      crc <= {1'b0, crc[7:1]} ^ (fb ? pfc_pkg::CRC_POLY_REV : pfc_pkg::CRC_INIT);
    end
  end
endmodule

// ===== pfc_function_unit.sv
// Behaviour
// - Hold 64-bit identity: family byte, 48-bit serial, then CRC byte.
// - CRC register starts at zero, family then serial shifted in LSB first.
// - Command byte then data bytes, every byte least significant bit first.
// - Wiper commands change the wiper only when the select field (bits 1:0) is 00.
// - Read position returns control byte then wiper byte.
// - After read position bytes, further reads return zeros until reset.
// - Write position echoes the received wiper byte over eight reads.
// - Release code 96h applies new position, then zeros until reset.
// - Wrong release code keeps old position, then ones until reset.
// - Read control returns feature byte then control byte.
// - After read control bytes, further reads return zeros until reset.
// - Write control echoes valid value, FFh for an illegal one.
// - Control commit on 96h for a legal value, then zeros; other codes unchanged and ones.
// - Increment raises position by one, saturating at FFh, returns new value.
// - After increment or decrement, accept another function command directly.
// - Decrement lowers position by one, floor 00h, returns new value.
// - Feature byte is fixed at F3h.
// - Control: bit 6 pump, 1:0 select, 3:2 complement; two legal values.
`timescale 1ns/1ps
module pfc_function_unit #(
  parameter logic [7:0]  FAMILY_CODE = 8'h00_5A,      // Arbitrary value
  parameter logic [47:0] SERIAL_NUM  = 48'h0000_0000_0001 // Arbitrary value
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        bus_reset,
  input  wire logic        fn_start,
  input  wire logic        wr_valid,
  input  wire logic        wr_bit,
  input  wire logic        rd_req,
  output logic             rd_valid,
  output logic             rd_bit,
  output logic [7:0]       wiper_pos,
  output logic             pump_enable_bit,
  output logic [1:0]       wiper_select,
  output logic [63:0]      rom_code,
  output logic             rom_valid
);
  pfc_pkg::pfc_state_t state;
  logic [7:0]  ctrl;
  logic [7:0]  rx_sh;
  logic [7:0]  cmd;
  logic [2:0]  bit_cnt;
  logic [15:0] tx_sh;
  logic [3:0]  tx_cnt;
  logic        tail_one;
  logic        back_to_cmd;
  logic [5:0]  rom_cnt;
  logic        rom_busy;
  logic [7:0]  crc;
  logic [55:0] id56;
  logic [7:0]  next_byte;
  logic        byte_done;
  logic        ctrl_ok;
  logic        sel_ok;
  logic [7:0]  next_up;
  logic [7:0]  next_down;
  logic [7:0]  held;

  assign id56      = {SERIAL_NUM, FAMILY_CODE};
  assign next_byte = {wr_bit, rx_sh[7:1]};
  assign byte_done = wr_valid && (bit_cnt == pfc_pkg::BIT_LAST);
  assign ctrl_ok   = (held == pfc_pkg::CTRL_PUMP_OFF) || (held == pfc_pkg::CTRL_PUMP_ON);
  assign sel_ok    = (ctrl[1:0] == pfc_pkg::WIPER_ONLY);
  assign next_up   = (wiper_pos == pfc_pkg::WIPER_MAX) ? wiper_pos : wiper_pos + 8'h01;
  assign next_down = (wiper_pos == pfc_pkg::WIPER_MIN) ? wiper_pos : wiper_pos - 8'h01;

  pfc_crc8 u_crc (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clear   (1'b0),
    .shift   (rom_busy),
    .din     (id56[rom_cnt]),
    .crc     (crc)
  );

  // Identity number assembly after reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rom_cnt   <= 6'h00;
      rom_busy  <= 1'b1;
      rom_valid <= 1'b0;
      rom_code  <= 64'h0000_0000_0000_0000;
    end else if (rom_busy) begin
      if (rom_cnt == pfc_pkg::ID_LAST) begin
        rom_busy <= 1'b0;
      end else begin
        rom_cnt <= rom_cnt + 6'h01;
      end
    end else if (!rom_valid) begin
      rom_code  <= {crc, id56};
      rom_valid <= 1'b1;
    end
  end

  // Bit counter for received bytes
  always_ff @(posedge sys_clk) begin
    if (rst || bus_reset || fn_start) begin
      bit_cnt <= 3'h0;
      rx_sh   <= 8'h00;
    end else if (wr_valid && (state == pfc_pkg::ST_CMD || state == pfc_pkg::ST_RXDATA ||
                              state == pfc_pkg::ST_RXREL)) begin
      bit_cnt <= bit_cnt + 3'h1;
      rx_sh   <= next_byte;
    end
  end

  // Command sequencer
  always_ff @(posedge sys_clk) begin
    if (rst || bus_reset) begin
      state       <= pfc_pkg::ST_IDLE;
      cmd         <= 8'h00;
      tx_sh       <= 16'h0000;
      tx_cnt      <= 4'h0;
      tail_one    <= 1'b1;
      back_to_cmd <= 1'b0;
    end else begin
      case (state)
        pfc_pkg::ST_IDLE: begin
          if (fn_start) begin
            state <= pfc_pkg::ST_CMD;
          end
        end
        pfc_pkg::ST_CMD: begin
          if (byte_done) begin
            cmd         <= next_byte;
            back_to_cmd <= 1'b0;
            case (next_byte)
              pfc_pkg::CMD_READ_POS: begin
                tx_sh  <= {wiper_pos, ctrl};
                tx_cnt <= pfc_pkg::TX_TWO_BYTES;
                state  <= pfc_pkg::ST_SEND;
              end
              pfc_pkg::CMD_READ_CTRL: begin
                tx_sh  <= {ctrl, pfc_pkg::FEATURE_VALUE};
                tx_cnt <= pfc_pkg::TX_TWO_BYTES;
                state  <= pfc_pkg::ST_SEND;
              end
              pfc_pkg::CMD_WRITE_POS, pfc_pkg::CMD_WRITE_CTRL: begin
                state <= pfc_pkg::ST_RXDATA;
              end
              pfc_pkg::CMD_INC: begin
                tx_sh       <= {8'h00, sel_ok ? next_up : wiper_pos};
                tx_cnt      <= pfc_pkg::TX_ONE_BYTE;
                back_to_cmd <= 1'b1;
                state       <= pfc_pkg::ST_SEND;
              end
              pfc_pkg::CMD_DEC: begin
                tx_sh       <= {8'h00, sel_ok ? next_down : wiper_pos};
                tx_cnt      <= pfc_pkg::TX_ONE_BYTE;
                back_to_cmd <= 1'b1;
                state       <= pfc_pkg::ST_SEND;
              end
              default: begin
                tail_one <= 1'b1;
                state    <= pfc_pkg::ST_TAIL;
              end
            endcase
          end
        end
        pfc_pkg::ST_RXDATA: begin
          if (byte_done) begin
            tx_cnt <= pfc_pkg::TX_ONE_BYTE;
            state  <= pfc_pkg::ST_ECHO;
            if (cmd == pfc_pkg::CMD_WRITE_CTRL &&
                next_byte != pfc_pkg::CTRL_PUMP_OFF && next_byte != pfc_pkg::CTRL_PUMP_ON) begin
              tx_sh <= {8'h00, pfc_pkg::ECHO_REJECT};
            end else begin
              tx_sh <= {8'h00, next_byte};
            end
          end
        end
        pfc_pkg::ST_ECHO: begin
          if (rd_req) begin
            tx_sh  <= {1'b0, tx_sh[15:1]};
            tx_cnt <= tx_cnt - 4'h1;
            if (tx_cnt == 4'h0) begin
              state <= pfc_pkg::ST_RXREL;
            end
          end
        end
        pfc_pkg::ST_RXREL: begin
          if (byte_done) begin
            tail_one <= (next_byte != pfc_pkg::RELEASE_CODE);
            state    <= pfc_pkg::ST_TAIL;
          end
        end
        pfc_pkg::ST_SEND: begin
          if (rd_req) begin
            tx_sh  <= {1'b0, tx_sh[15:1]};
            tx_cnt <= tx_cnt - 4'h1;
            if (tx_cnt == 4'h0) begin
              tail_one <= 1'b0;
              state    <= back_to_cmd ? pfc_pkg::ST_CMD : pfc_pkg::ST_TAIL;
            end
          end
        end
        pfc_pkg::ST_TAIL: begin
          state <= pfc_pkg::ST_TAIL;
        end
        default: begin
          state <= pfc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Wiper position
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wiper_pos <= pfc_pkg::WIPER_RESET;
    end else if (!bus_reset && state == pfc_pkg::ST_CMD && byte_done && sel_ok) begin
      if (next_byte == pfc_pkg::CMD_INC) begin
        wiper_pos <= next_up;
      end else if (next_byte == pfc_pkg::CMD_DEC) begin
        wiper_pos <= next_down;
      end
    end else if (!bus_reset && state == pfc_pkg::ST_RXREL && byte_done &&
                 cmd == pfc_pkg::CMD_WRITE_POS && sel_ok &&
                 next_byte == pfc_pkg::RELEASE_CODE) begin
      wiper_pos <= held;
    end
  end

  // Received data byte kept for the release stage
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      held <= 8'h00;
    end else if (state == pfc_pkg::ST_RXDATA && byte_done) begin
      held <= next_byte;
    end
  end

  // Control register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl <= pfc_pkg::CTRL_RESET;
    end else if (!bus_reset && state == pfc_pkg::ST_RXREL && byte_done &&
                 cmd == pfc_pkg::CMD_WRITE_CTRL && next_byte == pfc_pkg::RELEASE_CODE &&
                 ctrl_ok) begin
      ctrl <= held;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pump_enable_bit <= 1'b0;
      wiper_select    <= 2'h0;
    end else begin
      pump_enable_bit <= ctrl[pfc_pkg::CTRL_PUMP_BIT];
      wiper_select    <= ctrl[pfc_pkg::CTRL_SEL_LSB +: 2];
    end
  end

  // Read slot answers; idle answer is a released line (one)
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_valid <= 1'b0;
      rd_bit   <= 1'b1;
    end else begin
      rd_valid <= rd_req && !bus_reset;
      if (state == pfc_pkg::ST_SEND || state == pfc_pkg::ST_ECHO) begin
        rd_bit <= tx_sh[0];
      end else if (state == pfc_pkg::ST_TAIL) begin
        rd_bit <= tail_one;
      end else begin
        rd_bit <= 1'b1;
      end
    end
  end

  chk_reset_abort: assert property (@(posedge sys_clk) disable iff (rst)
    bus_reset |=> state == pfc_pkg::ST_IDLE) else $error("Bus reset did not abort");
  chk_read_pos_order: assert property (@(posedge sys_clk) disable iff (rst || bus_reset)
    (state == pfc_pkg::ST_CMD && byte_done && next_byte == pfc_pkg::CMD_READ_POS)
    |=> tx_sh == {$past(wiper_pos), $past(ctrl)} && tx_cnt == pfc_pkg::TX_TWO_BYTES)
    else $error("Read position bytes wrong");
  chk_read_ctrl_order: assert property (@(posedge sys_clk) disable iff (rst || bus_reset)
    (state == pfc_pkg::ST_CMD && byte_done && next_byte == pfc_pkg::CMD_READ_CTRL)
    |=> tx_sh == {$past(ctrl), pfc_pkg::FEATURE_VALUE}) else $error("Read control bytes wrong");
  chk_tail_zero: assert property (@(posedge sys_clk) disable iff (rst || bus_reset)
    (state == pfc_pkg::ST_TAIL && !tail_one && rd_req) |=> rd_valid && !rd_bit)
    else $error("Tail read not zero");
  chk_inc_saturate: assert property (@(posedge sys_clk) disable iff (rst || bus_reset)
    (state == pfc_pkg::ST_CMD && byte_done && next_byte == pfc_pkg::CMD_INC && sel_ok)
    |=> wiper_pos == (($past(wiper_pos) == pfc_pkg::WIPER_MAX) ? pfc_pkg::WIPER_MAX
                      : $past(wiper_pos) + 8'h01)) else $error("Increment wrong");
  chk_dec_floor: assert property (@(posedge sys_clk) disable iff (rst || bus_reset)
    (state == pfc_pkg::ST_CMD && byte_done && next_byte == pfc_pkg::CMD_DEC && sel_ok)
    |=> wiper_pos == (($past(wiper_pos) == pfc_pkg::WIPER_MIN) ? pfc_pkg::WIPER_MIN
                      : $past(wiper_pos) - 8'h01)) else $error("Decrement wrong");
  chk_ctrl_legal: assert property (@(posedge sys_clk) disable iff (rst)
    ctrl == pfc_pkg::CTRL_PUMP_OFF || ctrl == pfc_pkg::CTRL_PUMP_ON)
    else $error("Control register illegal");
  chk_echo_reject: assert property (@(posedge sys_clk) disable iff (rst || bus_reset)
    (state == pfc_pkg::ST_RXDATA && byte_done && cmd == pfc_pkg::CMD_WRITE_CTRL &&
     next_byte != pfc_pkg::CTRL_PUMP_OFF && next_byte != pfc_pkg::CTRL_PUMP_ON)
    |=> tx_sh[7:0] == pfc_pkg::ECHO_REJECT) else $error("Illegal control not rejected");
  chk_bad_release: assert property (@(posedge sys_clk) disable iff (rst || bus_reset)
    (state == pfc_pkg::ST_RXREL && byte_done && next_byte != pfc_pkg::RELEASE_CODE)
    |=> $stable(wiper_pos) && $stable(ctrl) && tail_one) else $error("Bad release acted");
  chk_fn_loop: assert property (@(posedge sys_clk) disable iff (rst || bus_reset)
    (state == pfc_pkg::ST_SEND && back_to_cmd && rd_req && tx_cnt == 4'h0)
    |=> state == pfc_pkg::ST_CMD) else $error("No return to command level");
  chk_rom_layout: assert property (@(posedge sys_clk) disable iff (rst)
    rom_valid |-> rom_code[55:0] == id56) else $error("Identity layout wrong");

  cov_read_pos: cover property (@(posedge sys_clk) disable iff (rst)
    state == pfc_pkg::ST_CMD && byte_done && next_byte == pfc_pkg::CMD_READ_POS);
  cov_pos_commit: cover property (@(posedge sys_clk) disable iff (rst)
    state == pfc_pkg::ST_RXREL && byte_done && next_byte == pfc_pkg::RELEASE_CODE);
  cov_inc_then_cmd: cover property (@(posedge sys_clk) disable iff (rst)
    state == pfc_pkg::ST_SEND && back_to_cmd ##[1:40] state == pfc_pkg::ST_CMD);
endmodule

// ===== pfc_master_model.sv
`timescale 1ns/1ps
module pfc_master_model (
  input  wire logic sys_clk,
  input  wire logic rd_valid,
  input  wire logic rd_bit,
  output logic      bus_reset,
  output logic      fn_start,
  output logic      wr_valid,
  output logic      wr_bit,
  output logic      rd_req
);
  initial begin
    bus_reset = 1'b0;
    fn_start  = 1'b0;
    wr_valid  = 1'b0;
    wr_bit    = 1'b1;
    rd_req    = 1'b0;
  end

  // Enter the function level after the ROM stage
  task automatic start();
    @(posedge sys_clk);
    fn_start <= 1'b1;
    @(posedge sys_clk);
    fn_start <= 1'b0;
  endtask

  // Write one byte, least significant bit first
  task automatic wr_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      wr_valid <= 1'b1;
      wr_bit   <= b[i];
    end
    @(posedge sys_clk);
    wr_valid <= 1'b0;
    wr_bit   <= ~b[7];
  endtask

  // Read one byte, least significant bit first; a missing answer reads unknown
  task automatic rd_byte(output logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      rd_req <= 1'b1;
      @(posedge sys_clk);
      rd_req <= 1'b0;
      #1;
      b[i] = (rd_valid === 1'b1) ? rd_bit : 1'bx;
    end
  endtask

  // Every start is closed by a bus reset; chained increment and decrement commands share one
  task automatic breset();
    @(posedge sys_clk);
    bus_reset <= 1'b1;
    @(posedge sys_clk);
    bus_reset <= 1'b0;
    @(posedge sys_clk);
  endtask
endmodule

// ===== pot_function_command_unit_bench.sv
`timescale 1ns/1ps
module pot_function_command_unit_bench;
  localparam logic [7:0]  FAM = 8'h00_A7;             // Arbitrary value
  localparam logic [47:0] SER = 48'h1234_5678_9ABC;   // Arbitrary value
  localparam int          CYCLE_LIMIT = 20000;
  logic        sys_clk;
  logic        rst;
  logic        bus_reset;
  logic        fn_start;
  logic        wr_valid;
  logic        wr_bit;
  logic        rd_req;
  logic        rd_valid;
  logic        rd_bit;
  logic [7:0]  wiper_pos;
  logic        pump_enable_bit;
  logic [1:0]  wiper_select;
  logic [63:0] rom_code;
  logic        rom_valid;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          cycles = 0;

  pfc_function_unit #(.FAMILY_CODE(FAM), .SERIAL_NUM(SER)) dut (
    .sys_clk(sys_clk), .rst(rst), .bus_reset(bus_reset), .fn_start(fn_start),
    .wr_valid(wr_valid), .wr_bit(wr_bit), .rd_req(rd_req), .rd_valid(rd_valid),
    .rd_bit(rd_bit), .wiper_pos(wiper_pos), .pump_enable_bit(pump_enable_bit),
    .wiper_select(wiper_select), .rom_code(rom_code), .rom_valid(rom_valid)
  );
  pfc_master_model master (
    .sys_clk(sys_clk), .rd_valid(rd_valid), .rd_bit(rd_bit), .bus_reset(bus_reset),
    .fn_start(fn_start), .wr_valid(wr_valid), .wr_bit(wr_bit), .rd_req(rd_req)
  );

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic end_sim();
    $display("Checks made %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == CYCLE_LIMIT) begin
      n_mismatch++;
      $display("Error timeout expected finish seen hang");
      end_sim();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
    logic fb;
    fb = c[0] ^ b;
    crc_step = fb ? ((c >> 1) ^ 8'h00_8C) : (c >> 1);
  endfunction

  // Write sequence with echo check; aborts by bus reset on a bad echo
  task automatic wseq(input logic [7:0] cmd, input logic [7:0] val, input logic [7:0] rel,
                      input logic [7:0] exp_echo, input logic [7:0] exp_tail);
    logic [7:0] b;
    master.start();
    master.wr_byte(cmd);
    master.wr_byte(val);
    master.rd_byte(b);
    chk("echo", exp_echo, b);
    if (b !== val) begin
      master.breset();
      return;
    end
    master.wr_byte(rel);
    master.rd_byte(b);
    chk("tail", exp_tail, b);
    master.breset();
  endtask

  task automatic t_rom();
    logic [63:0] exp;
    logic [7:0]  c;
    int          k;
    for (k = 0; k < 200 && rom_valid !== 1'b1; k++) @(posedge sys_clk);
    chk("rom_valid", 8'h00_01, {7'h00, rom_valid});
    exp[55:0] = {SER, FAM};
    c = 8'h00_00;
    for (k = 0; k < 56; k++) c = crc_step(c, exp[k]);
    exp[63:56] = c;
    for (k = 0; k < 8; k++) chk("rom_code byte", exp[8*k+:8], rom_code[8*k+:8]);
    for (k = 56; k < 64; k++) c = crc_step(c, rom_code[k]);
    chk("crc residue", 8'h00_00, c);
    $display("Test rom done");
  endtask

  task automatic t_unknown();
    logic [7:0] b;
    master.start();
    master.wr_byte(8'h00_3C);
    master.rd_byte(b);
    chk("unknown command tail", 8'h00_FF, b);
    master.breset();
    $display("Test unknown command done");
  endtask

  task automatic t_rdctrl();
    logic [7:0] b;
    master.start();
    master.wr_byte(pfc_pkg::CMD_READ_CTRL);
    master.rd_byte(b);
    chk("feature", 8'h00_F3, b);
    master.rd_byte(b);
    chk("control", 8'h00_0C, b);
    master.rd_byte(b);
    chk("read control tail", 8'h00_00, b);
    master.breset();
    $display("Test read control done");
  endtask

  task automatic t_wpos();
    wseq(8'h00_0F, 8'h00_80, 8'h00_96, 8'h00_80, 8'h00_00);
    chk("wiper_pos", 8'h00_80, wiper_pos);
    wseq(8'h00_0F, 8'h00_33, 8'h00_69, 8'h00_33, 8'h00_FF);
    chk("wiper_pos", 8'h00_80, wiper_pos);
    $display("Test write position done");
  endtask

  task automatic t_rdpos();
    logic [7:0] b;
    master.start();
    master.wr_byte(pfc_pkg::CMD_READ_POS);
    master.rd_byte(b);
    chk("position control", 8'h00_0C, b);
    master.rd_byte(b);
    chk("position", 8'h00_80, b);
    master.rd_byte(b);
    chk("read position tail", 8'h00_00, b);
    master.breset();
    $display("Test read position done");
  endtask

  task automatic t_wctrl();
    wseq(8'h00_55, 8'h00_3C, 8'h00_96, 8'h00_FF, 8'h00_00);
    chk("pump", 8'h00_00, {7'h00, pump_enable_bit});
    wseq(8'h00_55, 8'h00_4C, 8'h00_69, 8'h00_4C, 8'h00_FF);
    chk("pump", 8'h00_00, {7'h00, pump_enable_bit});
    wseq(8'h00_55, 8'h00_4C, 8'h00_96, 8'h00_4C, 8'h00_00);
    chk("pump", 8'h00_01, {7'h00, pump_enable_bit});
    chk("select", 8'h00_00, {6'h00, wiper_select});
    wseq(8'h00_55, 8'h00_0C, 8'h00_96, 8'h00_0C, 8'h00_00);
    chk("pump", 8'h00_00, {7'h00, pump_enable_bit});
    $display("Test write control done");
  endtask

  task automatic step(input logic [7:0] cmd, input logic [7:0] exp);
    logic [7:0] b;
    master.wr_byte(cmd);
    master.rd_byte(b);
    chk("step answer", exp, b);
    chk("wiper_pos", exp, wiper_pos);
  endtask

  task automatic t_incdec();
    wseq(8'h00_0F, 8'h00_FE, 8'h00_96, 8'h00_FE, 8'h00_00);
    master.start();
    step(pfc_pkg::CMD_INC, 8'h00_FF);
    step(pfc_pkg::CMD_INC, 8'h00_FF);
    step(pfc_pkg::CMD_DEC, 8'h00_FE);
    master.breset();
    wseq(8'h00_0F, 8'h00_01, 8'h00_96, 8'h00_01, 8'h00_00);
    master.start();
    step(pfc_pkg::CMD_DEC, 8'h00_00);
    step(pfc_pkg::CMD_DEC, 8'h00_00);
    master.breset();
    $display("Test increment decrement done");
  endtask

  initial begin
    rst = 1'b1;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    t_rom();
    t_unknown();
    t_rdctrl();
    t_wpos();
    t_rdpos();
    t_wctrl();
    t_incdec();
    end_sim();
  end
endmodule
